// ==== hdl/umb_uart_ctrl.sv ====
// mode, error status and baud generation of the asynchronous serial unit
`timescale 1ns/1ps
`default_nettype none
`include "umb_uart_regs.svh"

module umb_uart_ctrl import umb_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_wdata,
  input wire logic serial_receive_pin,
  input wire logic aux_timer_output,
  output logic [7:0] cpu_rdata,
  output logic serial_transmit_pin,
  output logic rx_full
);

  // ==========================================================
  // cpu registers
  logic [7:0] mode;
  logic [7:0] baud;
  wire wr_mode = cpu_wr && (cpu_addr == `UMB_MODE_ADDR);
  wire wr_baud = cpu_wr && (cpu_addr == `UMB_BAUD_ADDR);
  wire wr_txs = cpu_wr && (cpu_addr == `UMB_TX_SHIFT_ADDR);
  wire rd_status = cpu_rd && (cpu_addr == `UMB_STATUS_ADDR);
  wire rd_hold = cpu_rd && (cpu_addr == `UMB_RX_HOLD_ADDR);

  // control registers live outside the power-gated unit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode <= `UMB_MODE_RESET;
      baud <= `UMB_BAUD_RESET;
    end else begin
      if (wr_mode) mode <= cpu_wdata;
      if (wr_baud) baud <= cpu_wdata;
    end
  end

  // field decode
  wire unit_power_enable = mode[`UMB_POWER_BIT];
  wire tx_enable = mode[`UMB_TXE_BIT];
  wire rx_enable = mode[`UMB_RXE_BIT];
  wire [1:0] par_sel = mode[`UMB_PAR_HI:`UMB_PAR_LO];
  wire char_length_select = mode[`UMB_CLEN_BIT];
  wire stop_length_select = mode[`UMB_SLEN_BIT];
  wire [1:0] bclk_sel = baud[`UMB_BCLK_HI:`UMB_BCLK_LO];
  wire [4:0] baud_k = baud[`UMB_DIV_HI:`UMB_DIV_LO];
  wire [2:0] last_bit = char_length_select ? 3'h7 : 3'h6;
  wire par_on = (par_sel != UMB_PAR_NONE);
  wire par_check = par_sel[1];

  // power low holds the whole unit in asynchronous reset
  wire unit_rst = rst | ~unit_power_enable;

  // ==========================================================
  // pin synchronisers
  logic rx_meta;
  logic rx_sync;
  logic tmr_meta;
  logic tmr_sync;
  logic tmr_prev;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
      tmr_meta <= 1'b0;
      tmr_sync <= 1'b0;
      tmr_prev <= 1'b0;
    end else begin
      rx_meta <= serial_receive_pin;
      rx_sync <= rx_meta;
      tmr_meta <= aux_timer_output;
      tmr_sync <= tmr_meta;
      tmr_prev <= tmr_sync;
    end
  end

  // receive line forced high while the unit is off
  wire rx_line = unit_power_enable ? rx_sync : 1'b1;

  // ==========================================================
  // baud generator
  logic [4:0] pre_cnt;
  logic [4:0] div_cnt;
  logic half_ph;
  always_ff @(posedge clk or posedge unit_rst) begin
    if (unit_rst) pre_cnt <= 5'h00;
    else pre_cnt <= pre_cnt + 5'h01;
  end

  // base clock choice as a one-cycle enable
  wire tmr_rise = tmr_sync & ~tmr_prev;
  wire base_tick = (bclk_sel == 2'h0) ? tmr_rise :
                   (bclk_sel == 2'h1) ? (pre_cnt[0] == 1'b1) :
                   (bclk_sel == 2'h2) ? (pre_cnt[2:0] == 3'h7) :
                   (pre_cnt == 5'h1f);
  wire div_wrap = (div_cnt == baud_k - 5'h01);
  wire div_tick = base_tick && div_wrap;
  wire bit_tick = div_tick && half_ph;

  // k below 8 is not legal; k 1 to 7 wrap sooner, k 0 wraps after 32 counts
  always_ff @(posedge clk or posedge unit_rst) begin
    if (unit_rst) begin
      div_cnt <= 5'h00;
      half_ph <= 1'b0;
    end else if (base_tick) begin
      div_cnt <= div_wrap ? 5'h00 : div_cnt + 5'h01;
      if (div_wrap) half_ph <= ~half_ph;
    end
  end

  // ==========================================================
  // enables resampled on the base clock
  logic tx_en_s;
  logic rx_en_s;
  always_ff @(posedge clk or posedge unit_rst) begin
    if (unit_rst) begin
      tx_en_s <= 1'b0;
      rx_en_s <= 1'b0;
    end else if (base_tick) begin
      tx_en_s <= tx_enable;
      rx_en_s <= rx_enable;
    end
  end

  // ==========================================================
  // transmitter: state names the bit sent at the next bit tick
  umb_tx_state_type tx_state;
  logic [7:0] tx_shift_register;
  logic [2:0] tx_cnt;
  logic tx_par;
  wire [7:0] tx_mask = char_length_select ? cpu_wdata : {1'b0, cpu_wdata[6:0]};
  wire next_tx_par = (par_sel == UMB_PAR_ODD) ? ~^tx_mask :
                     (par_sel == UMB_PAR_EVEN) ? ^tx_mask : 1'b0;
  wire tx_load = wr_txs && tx_en_s && (tx_state == UMB_TX_IDLE);

  always_ff @(posedge clk or posedge unit_rst) begin
    if (unit_rst) begin
      tx_state <= UMB_TX_IDLE;
      tx_shift_register <= `UMB_DATA_RESET;
      tx_cnt <= 3'h0;
      tx_par <= 1'b0;
      serial_transmit_pin <= 1'b1;
    end else if (!tx_en_s) begin
      tx_state <= UMB_TX_IDLE;
      tx_shift_register <= `UMB_DATA_RESET;
      tx_cnt <= 3'h0;
      serial_transmit_pin <= 1'b1;
    end else if (tx_load) begin
      tx_state <= UMB_TX_START;
      tx_shift_register <= cpu_wdata;
      tx_par <= next_tx_par;
      tx_cnt <= 3'h0;
    end else if (bit_tick) begin
      case (tx_state)
        UMB_TX_START: begin
          serial_transmit_pin <= 1'b0;
          tx_state <= UMB_TX_DATA;
        end
        UMB_TX_DATA: begin
          serial_transmit_pin <= tx_shift_register[0];
          tx_shift_register <= {1'b1, tx_shift_register[7:1]};
          tx_cnt <= tx_cnt + 3'h1;
          if (tx_cnt == last_bit) tx_state <= par_on ? UMB_TX_PARITY : UMB_TX_STOP1;
        end
        UMB_TX_PARITY: begin
          serial_transmit_pin <= tx_par;
          tx_state <= UMB_TX_STOP1;
        end
        UMB_TX_STOP1: begin
          serial_transmit_pin <= 1'b1;
          tx_state <= stop_length_select ? UMB_TX_STOP2 : UMB_TX_DONE;
        end
        UMB_TX_STOP2: begin
          serial_transmit_pin <= 1'b1;
          tx_state <= UMB_TX_DONE;
        end
        UMB_TX_DONE: tx_state <= UMB_TX_IDLE;
        default: tx_state <= UMB_TX_IDLE;
      endcase
    end
  end

  // ==========================================================
  // receiver: samples every second half-bit tick after the start edge
  umb_rx_state_type rx_state;
  logic [7:0] rx_shift;
  logic [2:0] rx_cnt;
  logic rx_ph;
  logic rx_par;
  wire rx_sample = div_tick && rx_ph;
  wire rx_done = rx_sample && (rx_state == UMB_RX_STOP);
  // rx_par starts at the select's low bit, so a good frame leaves it at one for odd and even alike
  wire set_pe = rx_done && par_check && !rx_par;
  wire set_fe = rx_done && !rx_line;
  wire set_ov = rx_done && rx_full;

  always_ff @(posedge clk or posedge unit_rst) begin
    if (unit_rst) begin
      rx_state <= UMB_RX_IDLE;
      rx_shift <= 8'h00;
      rx_cnt <= 3'h0;
      rx_ph <= 1'b0;
      rx_par <= 1'b0;
    end else if (!rx_en_s) begin
      rx_state <= UMB_RX_IDLE;
      rx_cnt <= 3'h0;
      rx_ph <= 1'b0;
    end else if (div_tick) begin
      rx_ph <= ~rx_ph;
      case (rx_state)
        UMB_RX_IDLE: begin
          rx_ph <= 1'b0;
          rx_cnt <= 3'h0;
          rx_par <= par_sel[0];
          rx_shift <= 8'h00;
          if (!rx_line) rx_state <= UMB_RX_DATA;
        end
        UMB_RX_DATA: if (rx_ph) begin
          rx_shift[rx_cnt] <= rx_line;
          rx_par <= rx_par ^ rx_line;
          rx_cnt <= rx_cnt + 3'h1;
          if (rx_cnt == last_bit) rx_state <= par_on ? UMB_RX_PARITY : UMB_RX_STOP;
        end
        UMB_RX_PARITY: if (rx_ph) begin
          rx_par <= rx_par ^ rx_line;
          rx_state <= UMB_RX_STOP;
        end
        UMB_RX_STOP: if (rx_ph) rx_state <= UMB_RX_IDLE;
        default: rx_state <= UMB_RX_IDLE;
      endcase
    end
  end

  // ==========================================================
  // holding register and error flags
  logic [7:0] rx_holding_register;
  logic [2:0] err;
  always_ff @(posedge clk or posedge unit_rst) begin
    if (unit_rst) begin
      rx_holding_register <= `UMB_DATA_RESET;
      rx_full <= 1'b0;
    end else if (rx_done && !rx_full) begin
      rx_holding_register <= rx_shift;
      rx_full <= 1'b1;
    end else if (rd_hold) begin
      rx_full <= 1'b0;
    end
  end

  // a new error in the cycle of a status read survives the read
  always_ff @(posedge clk or posedge unit_rst) begin
    if (unit_rst) err <= 3'h0;
    else err <= (err & {3{~rd_status}}) | {set_pe, set_fe, set_ov};
  end

  // ==========================================================
  // read data, one cycle after the strobe; unmapped reads zero
  wire [7:0] status_word = {5'h00, err};
  wire [7:0] next_rdata = !cpu_rd ? cpu_rdata :
                          (cpu_addr == `UMB_MODE_ADDR) ? mode :
                          (cpu_addr == `UMB_BAUD_ADDR) ? {baud[7:6], 1'b0, baud[4:0]} :
                          (cpu_addr == `UMB_STATUS_ADDR) ? status_word :
                          (cpu_addr == `UMB_RX_HOLD_ADDR) ? rx_holding_register : 8'h00;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cpu_rdata <= 8'h00;
    else cpu_rdata <= next_rdata;
  end

  // ==========================================================
  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_power_off_idle: assert property (!unit_power_enable |=> serial_transmit_pin && err == 3'h0)
    else $error("unit not held in reset while power is off");
  a_rx_forced_high: assert property (!unit_power_enable |-> rx_line)
    else $error("receive line not forced high while power is off");
  a_tx_disable_reset: assert property (unit_power_enable && !tx_en_s |=> tx_state == UMB_TX_IDLE)
    else $error("transmitter not reset while disabled");
  a_zero_parity_quiet: assert property (par_sel == UMB_PAR_ZERO && unit_power_enable |=> !err[2] || $past(err[2]))
    else $error("parity error raised under zero parity");
  a_overrun_keeps: assert property (unit_power_enable && set_ov && !rd_hold ##1 unit_power_enable
    |-> $stable(rx_holding_register) && err[0])
    else $error("overrun byte overwrote holding register");
  a_seven_bit_msb: assert property (unit_power_enable && rx_done && !rx_full && !char_length_select
    ##1 unit_power_enable |-> !rx_holding_register[7])
    else $error("seven-bit character has bit 7 set");
  a_div_spacing: assert property (div_tick && unit_power_enable && baud_k >= 5'h08
    && $stable(baud) |=> !div_tick [*7])
    else $error("divided tick closer than eight clocks");
  a_bit_half_rate: assert property (bit_tick |-> div_tick ##1 !bit_tick)
    else $error("bit tick not on alternate divided ticks");
  a_status_clear: assert property (unit_power_enable && rd_status && !rx_done ##1 unit_power_enable
    |-> err == 3'h0)
    else $error("status read left flags set");
  a_frame_start: assert property (tx_load |=> tx_state == UMB_TX_START)
    else $error("write did not start a frame");

endmodule // umb_uart_ctrl
`default_nettype wire

// ==== shared/umb_uart_regs.svh ====
// register map, field positions and reset values of the serial unit controls
// What this block does
// - power bit low holds the unit in asynchronous reset and resets status, transmit and holding registers
// - power bit low makes the receive input read as constant high
// - clearing transmit or receive enable disables and synchronously resets that circuit
// - parity select: none, zero, odd or even for sending and checking
// - zero parity is never checked and never sets the parity error flag
// - character length bit selects seven or eight data bits both ways
// - stop length bit selects one or two stop bits when sending
// - receiver always checks exactly one stop bit after data and parity
// - status read or power bit low clears all error flags; receive enable low leaves them
// - completed reception with wrong parity sets the parity error flag
// - completed reception without a valid stop bit sets the framing error flag
// - reception completing while holding register is unread sets overrun, discards byte
// - base clock select picks timer output or peripheral clock over 2, 8, 32
// - five-bit counter divides the base clock by the divisor, 8 to 31
// - serial bit rate is the five-bit counter output divided by two
// - writing the transmit shift register starts a frame when transmit is enabled and idle
// - seven-bit characters land in bits 0 to 6, bit 7 reads zero
`ifndef UMB_UART_REGS_SVH
`define UMB_UART_REGS_SVH

// ==========================================================
// addresses
`define UMB_MODE_ADDR 16'hff70
`define UMB_BAUD_ADDR 16'hff71
`define UMB_STATUS_ADDR 16'hff73
`define UMB_TX_SHIFT_ADDR 16'hff74
`define UMB_RX_HOLD_ADDR 16'hff75

// ==========================================================
// reset values
`define UMB_MODE_RESET 8'h01
`define UMB_BAUD_RESET 8'h1f
`define UMB_STATUS_RESET 8'h00
`define UMB_DATA_RESET 8'hff

// ==========================================================
// mode register fields
`define UMB_POWER_BIT 7
`define UMB_TXE_BIT 6
`define UMB_RXE_BIT 5
`define UMB_PAR_HI 4
`define UMB_PAR_LO 3
`define UMB_CLEN_BIT 2
`define UMB_SLEN_BIT 1

// ==========================================================
// baud register fields and status bits
`define UMB_BCLK_HI 7
`define UMB_BCLK_LO 6
`define UMB_DIV_HI 4
`define UMB_DIV_LO 0
`define UMB_PE_BIT 2
`define UMB_FE_BIT 1
`define UMB_OVE_BIT 0

`endif

// ==== shared/umb_pkg.sv ====
// types shared by the serial unit control logic
package umb_pkg;
  typedef enum logic [2:0] {
    UMB_TX_IDLE = 3'b000,
    UMB_TX_START = 3'b001,
    UMB_TX_DATA = 3'b010,
    UMB_TX_PARITY = 3'b011,
    UMB_TX_STOP1 = 3'b100,
    UMB_TX_STOP2 = 3'b101,
    UMB_TX_DONE = 3'b110
  } umb_tx_state_type;
  typedef enum logic [1:0] {
    UMB_RX_IDLE = 2'b00,
    UMB_RX_DATA = 2'b01,
    UMB_RX_PARITY = 2'b10,
    UMB_RX_STOP = 2'b11
  } umb_rx_state_type;
  typedef enum logic [1:0] {
    UMB_PAR_NONE = 2'b00,
    UMB_PAR_ZERO = 2'b01,
    UMB_PAR_ODD = 2'b10,
    UMB_PAR_EVEN = 2'b11
  } umb_parity_type;
endpackage

// ==== verification/umb_remote_peer.sv ====
// behavioural remote transceiver on the serial line
`timescale 1ns/1ps
`default_nettype none

module umb_remote_peer (
  input wire logic line_in,
  output logic line_out
);
  // line idles high, so enabling reception never lands mid-frame
  initial begin
    line_out = 1'b1;
  end

  // ==========================================================
  // frame out: start, data lsb first, parity if any, one stop
  task automatic send(input logic [7:0] d, input int n, input logic hp, input logic p, input logic stp,
                      input int bt);
    line_out = 1'b0;
    #(bt);
    for (int i = 0; i < n; i++) begin
      line_out = d[i];
      #(bt);
    end
    if (hp) begin
      line_out = p;
      #(bt);
    end
    line_out = stp;
    #(bt);
    line_out = 1'b1; // one idle bit before returning
    #(bt);
  endtask

  // ==========================================================
  // frame in: mid-bit samples; a start that never comes leaves ones
  task automatic capture(input int n, input int bt, output logic [11:0] b);
    int t;
    b = 12'hfff;
    t = 0;
    while (line_in !== 1'b0 && t < 20000) begin
      #1;
      t++;
    end
    #(bt / 2);
    for (int i = 0; i < n; i++) begin
      b[i] = line_in;
      #(bt);
    end
  endtask
endmodule // umb_remote_peer

`default_nettype wire

// ==== verification/tb_uart_mode_error_baud_control.sv ====
// self-checking bench of the serial unit mode, status and baud control
`timescale 1ns/1ps
`default_nettype none
`include "umb_uart_regs.svh"

module tb_uart_mode_error_baud_control import umb_pkg::*; ;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] cpu_addr = 16'h0000;
  logic cpu_wr = 1'b0;
  logic cpu_rd = 1'b0;
  logic [7:0] cpu_wdata = 8'h00;
  logic aux_tick = 1'b0;
  logic rx_line;
  logic [7:0] cpu_rdata;
  logic tx_line;
  logic rx_full;
  logic [7:0] r;
  logic [11:0] f;
  int err_total = 0;
  int comparisons = 0;
  localparam int BT = 256; // clk/2 base, k 8, then /2: 32 cycles a bit
  localparam int BT9 = 1152; // clk/8 base, k 9, then /2
  localparam int BTT = 1664; // timer rise every 104 ns, k 8, then /2
  localparam int BT32 = 4096; // clk/32 base, k 8, then /2

  // ==========================================================
  // clock and a free-running timer output
  initial begin
    forever #4 clk = ~clk;
  end
  // timer edges kept off the clock edge so the synchroniser never races
  initial begin
    #1;
    forever #52 aux_tick = ~aux_tick;
  end

  umb_uart_ctrl uut (.clk(clk), .rst(rst), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
    .cpu_wdata(cpu_wdata), .serial_receive_pin(rx_line), .aux_timer_output(aux_tick),
    .cpu_rdata(cpu_rdata), .serial_transmit_pin(tx_line), .rx_full(rx_full));
  umb_remote_peer peer (.line_in(tx_line), .line_out(rx_line));

  // ==========================================================
  // register bus, comparisons and verdict
  function automatic logic [7:0] mode(logic p, logic t, logic x, logic [1:0] par, logic cl, logic sl);
    return {p, t, x, par, cl, sl, 1'b1};
  endfunction
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = 1'b1;
    @(posedge clk);
    #1 cpu_wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    #1 cpu_addr = a;
    cpu_rd = 1'b1;
    @(posedge clk);
    #1 cpu_rd = 1'b0;
    d = cpu_rdata;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkf(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t frame got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [15:0] a, input logic [7:0] exp);
    rd(a, r);
    chk8(r, exp);
  endtask
  task automatic results();
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    rc(`UMB_MODE_ADDR, 8'h01);
    rc(`UMB_BAUD_ADDR, 8'h1f);
    rc(`UMB_STATUS_ADDR, 8'h00);
    rc(16'hff72, 8'h00);
  endtask
  task automatic t_tx_even();
    wr(`UMB_BAUD_ADDR, 8'h48);
    wr(`UMB_MODE_ADDR, mode(1'b1, 1'b0, 1'b0, UMB_PAR_EVEN, 1'b1, 1'b0));
    wr(`UMB_MODE_ADDR, mode(1'b1, 1'b1, 1'b1, UMB_PAR_EVEN, 1'b1, 1'b0));
    repeat (10) @(posedge clk);
    wr(`UMB_TX_SHIFT_ADDR, 8'h55);
    peer.capture(11, BT, f);
    chkf(f, {2'b11, ^8'h55, 8'h55, 1'b0});
  endtask
  task automatic t_rx_errors();
    peer.send(8'ha3, 8, 1'b1, ^8'ha3, 1'b1, BT);
    chk8({7'h00, rx_full}, 8'h01);
    rc(`UMB_STATUS_ADDR, 8'h00);
    rc(`UMB_RX_HOLD_ADDR, 8'ha3);
    peer.send(8'h5c, 8, 1'b1, ~^8'h5c, 1'b1, BT);
    rc(`UMB_STATUS_ADDR, 8'h04);
    rc(`UMB_STATUS_ADDR, 8'h00);
    rd(`UMB_RX_HOLD_ADDR, r);
    peer.send(8'h0f, 8, 1'b1, ^8'h0f, 1'b0, BT);
    rc(`UMB_STATUS_ADDR, 8'h02);
    rd(`UMB_RX_HOLD_ADDR, r);
    // a low stop bit reads as a fresh start; let that frame run out, then drain it
    repeat (400) @(posedge clk);
    rd(`UMB_STATUS_ADDR, r);
    rd(`UMB_RX_HOLD_ADDR, r);
    peer.send(8'h11, 8, 1'b1, ^8'h11, 1'b1, BT);
    peer.send(8'h22, 8, 1'b1, ^8'h22, 1'b1, BT);
    rc(`UMB_STATUS_ADDR, 8'h01);
    rc(`UMB_RX_HOLD_ADDR, 8'h11);
  endtask
  task automatic t_tx_abort();
    wr(`UMB_TX_SHIFT_ADDR, 8'h00);
    repeat (80) @(posedge clk);
    chk8({7'h00, tx_line}, 8'h00);
    wr(`UMB_MODE_ADDR, mode(1'b1, 1'b0, 1'b1, UMB_PAR_EVEN, 1'b1, 1'b0));
    repeat (20) @(posedge clk);
    chk8({7'h00, tx_line}, 8'h01);
  endtask
  task automatic t_seven_zero();
    wr(`UMB_MODE_ADDR, mode(1'b1, 1'b0, 1'b0, UMB_PAR_EVEN, 1'b1, 1'b0));
    wr(`UMB_MODE_ADDR, mode(1'b1, 1'b0, 1'b0, UMB_PAR_ZERO, 1'b0, 1'b1));
    repeat (8) @(posedge clk);
    wr(`UMB_MODE_ADDR, mode(1'b1, 1'b1, 1'b1, UMB_PAR_ZERO, 1'b0, 1'b1));
    repeat (10) @(posedge clk);
    wr(`UMB_TX_SHIFT_ADDR, 8'h36);
    peer.capture(11, BT, f);
    chkf(f, {3'b111, 1'b0, 7'h36, 1'b0});
    peer.send(8'h36, 7, 1'b1, 1'b1, 1'b1, BT);
    rc(`UMB_STATUS_ADDR, 8'h00);
    rc(`UMB_RX_HOLD_ADDR, 8'h36);
  endtask
  task automatic t_baud_nine();
    wr(`UMB_MODE_ADDR, mode(1'b1, 1'b0, 1'b0, UMB_PAR_ZERO, 1'b0, 1'b1));
    wr(`UMB_BAUD_ADDR, 8'h89);
    repeat (40) @(posedge clk);
    wr(`UMB_MODE_ADDR, mode(1'b1, 1'b1, 1'b1, UMB_PAR_ZERO, 1'b0, 1'b1));
    repeat (40) @(posedge clk);
    wr(`UMB_TX_SHIFT_ADDR, 8'h5a);
    peer.capture(11, BT9, f);
    chkf(f, {3'b111, 1'b0, 7'h5a, 1'b0});
  endtask
  task automatic t_power_off();
    peer.send(8'h00, 7, 1'b1, 1'b0, 1'b0, BT9);
    chk8({7'h00, rx_full}, 8'h01);
    wr(`UMB_MODE_ADDR, mode(1'b1, 1'b0, 1'b0, UMB_PAR_ZERO, 1'b0, 1'b1));
    repeat (40) @(posedge clk);
    wr(`UMB_MODE_ADDR, 8'h01);
    rc(`UMB_STATUS_ADDR, 8'h00);
    peer.send(8'h00, 7, 1'b1, 1'b0, 1'b0, BT9);
    chk8({7'h00, rx_full}, 8'h00);
    rc(`UMB_RX_HOLD_ADDR, 8'hff);
    chk8({7'h00, tx_line}, 8'h01);
  endtask
  // odd parity both ways on the timer base, then a send on the slowest divided base
  task automatic t_odd_timer();
    wr(`UMB_BAUD_ADDR, 8'h08);
    wr(`UMB_MODE_ADDR, mode(1'b1, 1'b0, 1'b0, UMB_PAR_ODD, 1'b1, 1'b0));
    wr(`UMB_MODE_ADDR, mode(1'b1, 1'b1, 1'b1, UMB_PAR_ODD, 1'b1, 1'b0));
    repeat (40) @(posedge clk);
    wr(`UMB_TX_SHIFT_ADDR, 8'h87);
    peer.capture(11, BTT, f);
    chkf(f, {2'b11, ~^8'h87, 8'h87, 1'b0});
    peer.send(8'h4b, 8, 1'b1, ~^8'h4b, 1'b1, BTT);
    rc(`UMB_STATUS_ADDR, 8'h00);
    rc(`UMB_RX_HOLD_ADDR, 8'h4b);
    peer.send(8'h4b, 8, 1'b1, ^8'h4b, 1'b1, BTT);
    rc(`UMB_STATUS_ADDR, 8'h04);
    rd(`UMB_RX_HOLD_ADDR, r);
    wr(`UMB_MODE_ADDR, mode(1'b1, 1'b0, 1'b0, UMB_PAR_ODD, 1'b1, 1'b0));
    repeat (80) @(posedge clk);
    wr(`UMB_BAUD_ADDR, 8'hc8);
    repeat (80) @(posedge clk);
    wr(`UMB_MODE_ADDR, mode(1'b1, 1'b1, 1'b1, UMB_PAR_ODD, 1'b1, 1'b0));
    repeat (80) @(posedge clk);
    wr(`UMB_TX_SHIFT_ADDR, 8'h2d);
    peer.capture(11, BT32, f);
    chkf(f, {2'b11, ~^8'h2d, 8'h2d, 1'b0});
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    t_reset();
    t_tx_even();
    t_rx_errors();
    t_tx_abort();
    t_seven_zero();
    t_baud_nine();
    t_power_off();
    t_odd_timer();
    results();
  end
endmodule // tb_uart_mode_error_baud_control

`default_nettype wire
